// >>> flash_prot_cfg.svh
// Constants of the flash write-protection and status block
`ifndef FLASH_PROT_CFG_SVH
`define FLASH_PROT_CFG_SVH

// Clock and timing
`define REF_CLK_PERIOD_PS   4000
`define SR_WRITE_TIME_NS    1000
`define SR_WRITE_CYCLES     ((`SR_WRITE_TIME_NS * 1000 + `REF_CLK_PERIOD_PS - 1) / `REF_CLK_PERIOD_PS)

// Command codes
`define CMD_SET_WRITE_LATCH   8'h06
`define CMD_CLR_WRITE_LATCH   8'h04
`define CMD_READ_STATUS_LO    8'h05
`define CMD_READ_STATUS_HI    8'h35
`define CMD_STATUS_WRITE      8'h01
`define CMD_PAGE_PROGRAM      8'h02
`define CMD_QUAD_PROGRAM      8'h32
`define CMD_SECTOR_ERASE      8'h20
`define CMD_BLOCK_ERASE_32K   8'h52
`define CMD_BLOCK_ERASE_64K   8'hD8
`define CMD_CHIP_ERASE_A      8'h60
`define CMD_CHIP_ERASE_B      8'hC7
`define CMD_SUSPEND           8'h75
`define CMD_RESUME            8'h7A
`define CMD_DEEP_POWER_DOWN   8'hB9
`define CMD_RELEASE_PD        8'hAB
`define CMD_SEC_ERASE         8'h44
`define CMD_SEC_PROGRAM       8'h42
`define CMD_QUAD_OUT_READ     8'h6B
`define CMD_QUAD_IO_READ      8'hEB
`define CMD_QUAD_WORD_READ    8'hE7

// Status word field positions
`define ST_BUSY        0
`define ST_WRITE_LATCH 1
`define ST_GUARD_LO    2
`define ST_GUARD_HI    6
`define ST_LOCK        7
`define ST_QUAD        9
`define ST_SEC_LOCK    10
`define ST_INVERT      14
`define ST_SUSPENDED   15

// Factory value of the non-volatile fields
`define STATUS_RESET   16'h0000

`endif

// >>> flash_prot_pkg.sv
// Types of the flash write-protection and status block
package flash_prot_pkg;

  // Gray coded in listed order; ST_IDLE and ST_BUSY_ARR differ in both bits
  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_BUSY_SR   = 2'b01,
    ST_BUSY_ARR  = 2'b11,
    ST_SUSPENDED = 2'b10
  } wr_state_t;

endpackage : flash_prot_pkg

// >>> flash_write_protect.sv
// Write-protection and status logic of a serial NOR flash
//
// Contract
// RULE1 - Set-write-latch command sets the write latch
// RULE2 - Latch clears at reset, disable, writes completing
// RULE3 - Deep power-down ignores all but release
// RULE4 - Lock bit plus low pin refuses status writes
// RULE5 - Lock bit zero: status write needs latch
// RULE6 - Lock bit plus high pin: writable after latch
// RULE7 - Guard bits only via unlocked status write
// RULE8 - Program/erase inside guarded area is rejected
// RULE9 - Top guard zero: fractions of 64KB blocks
// RULE10 - Top guard one: 4-32KB top/bottom regions
// RULE11 - Invert bit at 14 complements guarded area
// RULE12 - Chip erase only with uniform guard code
// RULE13 - Busy flag in bit 0 during operations
// RULE14 - Write latch in bit 1; zero refuses writes
// RULE15 - Lock at 7, guards 6..2, reserved bits
// RULE16 - Quad bit at 9 turns pins into lanes
// RULE17 - Host avoids quad bit with tied pins
// RULE18 - Security lock bit at 10 is one-time
// RULE19 - Suspended bit at 15: set 75H, clear 7AH
// RULE20 - Quad reads honoured only with quad bit
// RULE21 - Write commands must end on byte boundary
// RULE22 - Reserved bits read zero, ignore writes
`include "flash_prot_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_write_protect
  import flash_prot_pkg::*;
#(
  parameter int SR_WRITE_CYCLES = `SR_WRITE_CYCLES
)(
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        SI,
  input  wire logic        WP_N,
  input  wire logic        ARRAY_OP_DONE,
  output logic             SO,
  output logic             SO_OE,
  output logic             ARRAY_OP_START,
  output logic [7:0]       ARRAY_OP_CODE,
  output logic [23:0]      ARRAY_OP_ADDR,
  output logic             ARRAY_SUSPEND,
  output logic             QUAD_EN,
  output logic             QUAD_READ_OK,
  output logic             SEC_REGS_RO,
  output logic             DEEP_POWER_DOWN,
  output logic [15:0]      STATUS_WORD
);

  // Guarded-area decode for a 2MB array
  function automatic logic area_guarded(input logic [20:0] a, input logic [4:0] bp,
                                        input logic cmp);
    logic       hit;
    logic [5:0] n;
    logic [9:0] k;
    hit = 1'b0;
    n   = 6'h10;
    k   = 10'h008;
    case (bp[2:0])
      3'h1: begin n = 6'h1F; k = 10'h001; end
      3'h2: begin n = 6'h1E; k = 10'h002; end
      3'h3: begin n = 6'h1C; k = 10'h004; end
      3'h4: begin n = 6'h18; k = 10'h008; end
      default: begin n = 6'h10; k = 10'h008; end
    endcase
    if (bp[2:0] == 3'h0)
      hit = 1'b1;                                          // RULE10
    else if (bp[2:1] == 2'b11)
      hit = 1'b0;                                          // RULE10
    else if (!bp[4])
    begin
      if (!bp[3])
        hit = ({1'b0, a[20:16]} < n);                      // RULE9
      else
        hit = ({1'b0, a[20:16]} >= (6'h20 - n));           // RULE9
    end
    else
    begin
      if (!bp[3])
        hit = ({1'b0, a[20:12]} >= (10'h200 - k));         // RULE10
      else
        hit = ({1'b0, a[20:12]} < k);                      // RULE10
    end
    return hit ^ cmp;                                      // RULE11
  endfunction : area_guarded

  // Pin synchronisers; first stage feeds only the second
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic si_s1_r, si_s2_r;
  logic wp_s1_r, wp_s2_r;

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      cs_s3_r   <= 1'b1;
      si_s1_r   <= 1'b0;
      si_s2_r   <= 1'b0;
      wp_s1_r   <= 1'b1;
      wp_s2_r   <= 1'b1;
    end
    else
    begin
      sclk_s1_r <= SCLK;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      cs_s1_r   <= CS_N;
      cs_s2_r   <= cs_s1_r;
      cs_s3_r   <= cs_s2_r;
      si_s1_r   <= SI;
      si_s2_r   <= si_s1_r;
      wp_s1_r   <= WP_N;
      wp_s2_r   <= wp_s1_r;
    end
  end

  // Frame and protection state
  wr_state_t   state_r, state_nxt;
  logic [15:0] timer_r, timer_nxt;
  logic        wel_r, wel_nxt;
  logic [4:0]  bp_r, bp_nxt;
  logic        srp_r, srp_nxt, qe_r, qe_nxt, lb_r, lb_nxt;
  logic        cmp_r, cmp_nxt, sus_r, sus_nxt, dpd_r, dpd_nxt;
  logic [7:0]  sh_r, sh_nxt, op_r, op_nxt, out_r, out_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [15:0] wdat_r, wdat_nxt;
  logic [2:0]  bit_r, bit_nxt, byte_r, byte_nxt;
  logic        rd_r, rd_nxt, so_r, so_nxt, so_oe_r, so_oe_nxt;
  logic        start_r, start_nxt;
  logic [7:0]  acode_r, acode_nxt;
  logic [23:0] aaddr_r, aaddr_nxt;
  logic        qrd_r, qrd_nxt;

  logic        sclk_rise, sclk_fall, cs_rise, frame_ok, busy, hw_lock, wp_level;
  logic [7:0]  byte_in;
  logic [15:0] status;

  // Pins act as data lanes once the quad bit is set
  assign wp_level  = qe_r ? 1'b1 : wp_s2_r;                // RULE16
  assign hw_lock   = srp_r && !wp_level;                   // RULE4 RULE6
  // Both busy states share bit 0 of the Gray code, so busy is a plain register bit
  assign busy      = state_r[0];
  assign sclk_rise = sclk_s2_r && !sclk_s3_r && !cs_s2_r;
  assign sclk_fall = !sclk_s2_r && sclk_s3_r && !cs_s2_r;
  assign cs_rise   = cs_s2_r && !cs_s3_r;
  assign frame_ok  = (bit_r == 3'h0) && (byte_r != 3'h0);  // RULE21
  assign byte_in   = {sh_r[6:0], si_s2_r};
  // Reserved positions are constant zero
  assign status    = {sus_r, cmp_r, 3'b000, lb_r, qe_r, 1'b0,
                      srp_r, bp_r, wel_r, busy};           // RULE13 RULE14 RULE15 RULE22

  // Next-state logic: serial shifting, status readout, command execution
  always_comb
  begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    wel_nxt   = wel_r;
    bp_nxt    = bp_r;
    srp_nxt   = srp_r;
    qe_nxt    = qe_r;
    lb_nxt    = lb_r;
    cmp_nxt   = cmp_r;
    sus_nxt   = sus_r;
    dpd_nxt   = dpd_r;
    sh_nxt    = sh_r;
    op_nxt    = op_r;
    out_nxt   = out_r;
    addr_nxt  = addr_r;
    wdat_nxt  = wdat_r;
    bit_nxt   = bit_r;
    byte_nxt  = byte_r;
    rd_nxt    = rd_r;
    so_nxt    = so_r;
    so_oe_nxt = so_oe_r;
    start_nxt = 1'b0;
    acode_nxt = acode_r;
    aaddr_nxt = aaddr_r;
    qrd_nxt   = qrd_r;

    // Capture a bit on each serial rising edge
    if (sclk_rise)
    begin
      sh_nxt  = byte_in;
      bit_nxt = bit_r + 3'h1;
      if (bit_r == 3'h7)
      begin
        if (byte_r != 3'h7)
          byte_nxt = byte_r + 3'h1;
        case (byte_r)
          3'h0: op_nxt = byte_in;
          3'h1: begin addr_nxt[23:16] = byte_in; wdat_nxt[7:0] = byte_in; end
          3'h2: begin addr_nxt[15:8] = byte_in; wdat_nxt[15:8] = byte_in; end
          3'h3: addr_nxt[7:0] = byte_in;
          default: ;
        endcase
        // Status readout, continuous while the frame lasts
        if (byte_r == 3'h0 && !dpd_r)                      // RULE3
          rd_nxt = (byte_in == `CMD_READ_STATUS_LO) || (byte_in == `CMD_READ_STATUS_HI);
        if (byte_r == 3'h0 ? (byte_in == `CMD_READ_STATUS_HI) : (op_r == `CMD_READ_STATUS_HI))
          out_nxt = status[15:8];
        else
          out_nxt = status[7:0];
        // Quad reads go to the datapath only with lanes enabled
        if (byte_r == 3'h0 && !dpd_r && (byte_in == `CMD_QUAD_OUT_READ ||
            byte_in == `CMD_QUAD_IO_READ || byte_in == `CMD_QUAD_WORD_READ))
          qrd_nxt = qe_r;                                  // RULE20
      end
    end

    // Shift readout on falling edges so the host samples on rising
    if (sclk_fall && rd_r)
    begin
      so_nxt    = out_r[7];
      so_oe_nxt = 1'b1;
      out_nxt   = {out_r[6:0], 1'b0};
    end

    // Chip deselected: frame state returns to idle
    if (cs_s2_r)
    begin
      bit_nxt   = 3'h0;
      byte_nxt  = 3'h0;
      rd_nxt    = 1'b0;
      so_oe_nxt = 1'b0;
      qrd_nxt   = 1'b0;
    end

    // Execute on chip-select release
    if (cs_rise)
    begin
      if (dpd_r)
      begin
        if (op_r == `CMD_RELEASE_PD && byte_r != 3'h0)
          dpd_nxt = 1'b0;                                  // RULE3
      end
      else if (frame_ok)
      begin
        case (op_r)
          `CMD_SET_WRITE_LATCH: if (state_r == ST_IDLE) wel_nxt = 1'b1;   // RULE1
          `CMD_CLR_WRITE_LATCH: if (state_r == ST_IDLE) wel_nxt = 1'b0;   // RULE2
          `CMD_STATUS_WRITE:
            if (state_r == ST_IDLE && wel_r && !hw_lock && byte_r >= 3'h2) // RULE4 RULE5 RULE6
            begin
              bp_nxt  = wdat_r[`ST_GUARD_HI:`ST_GUARD_LO];                // RULE7
              srp_nxt = wdat_r[`ST_LOCK];
              if (byte_r >= 3'h3)
              begin
                qe_nxt  = wdat_r[`ST_QUAD];                               // RULE16
                lb_nxt  = lb_r | wdat_r[`ST_SEC_LOCK];                    // RULE18
                cmp_nxt = wdat_r[`ST_INVERT];                             // RULE11
              end
              state_nxt = ST_BUSY_SR;                                     // RULE13
              timer_nxt = 16'(SR_WRITE_CYCLES);
            end
          `CMD_PAGE_PROGRAM, `CMD_QUAD_PROGRAM, `CMD_SECTOR_ERASE,
          `CMD_BLOCK_ERASE_32K, `CMD_BLOCK_ERASE_64K:
            if (state_r == ST_IDLE && wel_r && byte_r >= 3'h4 &&           // RULE14
                !(op_r[1] && !op_r[4] && byte_r < 3'h5) &&
                !area_guarded(addr_r[20:0], bp_r, cmp_r))                 // RULE8
            begin
              start_nxt = 1'b1;
              state_nxt = ST_BUSY_ARR;
            end
          `CMD_CHIP_ERASE_A, `CMD_CHIP_ERASE_B:
            if (state_r == ST_IDLE && wel_r &&
                ((bp_r[2:0] == 3'h0 && !cmp_r) || (bp_r[2:0] == 3'h7 && cmp_r))) // RULE12
            begin
              start_nxt = 1'b1;
              state_nxt = ST_BUSY_ARR;
            end
          `CMD_SEC_ERASE, `CMD_SEC_PROGRAM:
            if (state_r == ST_IDLE && wel_r && !lb_r && byte_r >= 3'h4)   // RULE18
            begin
              start_nxt = 1'b1;
              state_nxt = ST_BUSY_ARR;
            end
          `CMD_SUSPEND:
            if (state_r == ST_BUSY_ARR)
            begin
              state_nxt = ST_SUSPENDED;
              sus_nxt   = 1'b1;                                           // RULE19
            end
          `CMD_RESUME:
            if (state_r == ST_SUSPENDED)
            begin
              state_nxt = ST_BUSY_ARR;
              sus_nxt   = 1'b0;                                           // RULE19
            end
          `CMD_DEEP_POWER_DOWN: if (state_r == ST_IDLE) dpd_nxt = 1'b1;
          default: ;
        endcase
        if (start_nxt)
        begin
          acode_nxt = op_r;
          aaddr_nxt = addr_r;
        end
      end
    end

    // Operation completion; the latch drops with the busy flag
    case (state_r)
      ST_BUSY_SR:
        if (timer_r <= 16'h0001)
        begin
          state_nxt = ST_IDLE;
          wel_nxt   = 1'b0;                                // RULE2
          timer_nxt = 16'h0000;
        end
        else
          timer_nxt = timer_r - 16'h0001;
      ST_BUSY_ARR:
        if (ARRAY_OP_DONE && !start_r)
        begin
          state_nxt = ST_IDLE;
          wel_nxt   = 1'b0;                                // RULE2
        end
      ST_IDLE, ST_SUSPENDED: ;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State registers; non-volatile fields take the factory value at reset
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      state_r <= ST_IDLE;
      timer_r <= 16'h0000;
      wel_r   <= 1'b0;                                     // RULE2
      bp_r    <= 5'h00;
      srp_r   <= 1'b0;
      qe_r    <= 1'b0;
      lb_r    <= 1'b0;
      cmp_r   <= 1'b0;
      sus_r   <= 1'b0;                                     // RULE19
      dpd_r   <= 1'b0;
      sh_r    <= 8'h00;
      op_r    <= 8'h00;
      out_r   <= 8'h00;
      addr_r  <= 24'h000000;
      wdat_r  <= 16'h0000;
      bit_r   <= 3'h0;
      byte_r  <= 3'h0;
      rd_r    <= 1'b0;
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
      start_r <= 1'b0;
      acode_r <= 8'h00;
      aaddr_r <= 24'h000000;
      qrd_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      wel_r   <= wel_nxt;
      bp_r    <= bp_nxt;
      srp_r   <= srp_nxt;
      qe_r    <= qe_nxt;
      lb_r    <= lb_nxt;
      cmp_r   <= cmp_nxt;
      sus_r   <= sus_nxt;
      dpd_r   <= dpd_nxt;
      sh_r    <= sh_nxt;
      op_r    <= op_nxt;
      out_r   <= out_nxt;
      addr_r  <= addr_nxt;
      wdat_r  <= wdat_nxt;
      bit_r   <= bit_nxt;
      byte_r  <= byte_nxt;
      rd_r    <= rd_nxt;
      so_r    <= so_nxt;
      so_oe_r <= so_oe_nxt;
      start_r <= start_nxt;
      acode_r <= acode_nxt;
      aaddr_r <= aaddr_nxt;
      qrd_r   <= qrd_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign SO              = so_r;
  assign SO_OE           = so_oe_r;
  assign ARRAY_OP_START  = start_r;
  assign ARRAY_OP_CODE   = acode_r;
  assign ARRAY_OP_ADDR   = aaddr_r;
  assign ARRAY_SUSPEND   = sus_r;
  assign QUAD_EN         = qe_r;
  assign QUAD_READ_OK    = qrd_r;
  assign SEC_REGS_RO     = lb_r;
  assign DEEP_POWER_DOWN = dpd_r;
  assign STATUS_WORD     = status;

endmodule : flash_write_protect

`default_nettype wire

// >>> flash_prot_sva.sv
// Checker of the write-protection and status block
`include "flash_prot_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_prot_sva
  import flash_prot_pkg::*;
#(
  parameter int SR_WRITE_CYCLES = 5
)(
  input wire logic        REF_CLK,
  input wire logic        RESET,
  input wire logic        SCLK,
  input wire logic        CS_N,
  input wire logic        SI,
  input wire logic        WP_N,
  input wire logic        ARRAY_OP_DONE,
  input wire logic        SO,
  input wire logic        SO_OE,
  input wire logic        ARRAY_OP_START,
  input wire logic [7:0]  ARRAY_OP_CODE,
  input wire logic [23:0] ARRAY_OP_ADDR,
  input wire logic        ARRAY_SUSPEND,
  input wire logic        QUAD_EN,
  input wire logic        QUAD_READ_OK,
  input wire logic        SEC_REGS_RO,
  input wire logic        DEEP_POWER_DOWN,
  input wire logic [15:0] STATUS_WORD
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  logic arr_r;
  logic arr_nxt;
  // Array op in flight, so status-write busy is not taken for it
  always_comb
  begin
    arr_nxt = arr_r;
    if (ARRAY_OP_START)
      arr_nxt = 1'b1;
    else if (ARRAY_OP_DONE && !ARRAY_SUSPEND)
      arr_nxt = 1'b0;
    if (RESET)
      arr_nxt = 1'b0;
  end
  always_ff @(posedge REF_CLK)
    arr_r <= arr_nxt;

  // Field mirrors and sticky bits
  a_quad_mirror: assert property (QUAD_EN == STATUS_WORD[`ST_QUAD])
    else $error("quad enable differs from status");
  a_quad_read: assert property (QUAD_READ_OK |-> QUAD_EN)
    else $error("quad read without quad bit");
  a_sec_sticky: assert property (SEC_REGS_RO |=> SEC_REGS_RO)
    else $error("security lock cleared");
  a_sec_mirror: assert property (SEC_REGS_RO == STATUS_WORD[`ST_SEC_LOCK])
    else $error("security lock differs from status");
  a_resv_zero: assert property (STATUS_WORD[13:11] == 3'h0 && !STATUS_WORD[8])
    else $error("reserved status bit set");
  a_susp_mirror: assert property (ARRAY_SUSPEND == STATUS_WORD[`ST_SUSPENDED])
    else $error("suspend differs from status");
  // Start needs the latch, raises busy; done clears both
  a_start_latch: assert property ($rose(ARRAY_OP_START) |-> $past(STATUS_WORD[1]))
    else $error("op started without write latch");
  a_start_busy: assert property (ARRAY_OP_START |=> STATUS_WORD[0] [*2])
    else $error("busy missing after start");
  a_done_clear: assert property (ARRAY_OP_DONE && arr_r && !ARRAY_SUSPEND |=>
    !STATUS_WORD[0] && !STATUS_WORD[1]) else $error("done left busy or latch");
  a_dpd_quiet: assert property (DEEP_POWER_DOWN |-> !SO_OE && !ARRAY_OP_START)
    else $error("activity in deep power-down");
  a_chip_uniform: assert property (ARRAY_OP_START && ARRAY_OP_CODE inside {8'h60, 8'hC7}
    |-> {STATUS_WORD[4:2], STATUS_WORD[14]} inside {4'h0, 4'hF})
    else $error("chip erase with mixed guard code");
  c_op_start: cover property (ARRAY_OP_START);
  c_suspend: cover property ($rose(ARRAY_SUSPEND));
  c_power_down: cover property ($rose(DEEP_POWER_DOWN));
endmodule : flash_prot_sva

bind flash_write_protect flash_prot_sva #(.SR_WRITE_CYCLES(SR_WRITE_CYCLES)) i_sva (
  .REF_CLK(REF_CLK), .RESET(RESET), .SCLK(SCLK), .CS_N(CS_N), .SI(SI), .WP_N(WP_N),
  .ARRAY_OP_DONE(ARRAY_OP_DONE), .SO(SO), .SO_OE(SO_OE), .ARRAY_OP_START(ARRAY_OP_START),
  .ARRAY_OP_CODE(ARRAY_OP_CODE), .ARRAY_OP_ADDR(ARRAY_OP_ADDR), .QUAD_EN(QUAD_EN),
  .ARRAY_SUSPEND(ARRAY_SUSPEND), .QUAD_READ_OK(QUAD_READ_OK), .SEC_REGS_RO(SEC_REGS_RO),
  .DEEP_POWER_DOWN(DEEP_POWER_DOWN), .STATUS_WORD(STATUS_WORD));
`default_nettype wire

// >>> spi_host_model.sv
// Host serial controller model on the link side
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  output logic       sclk,
  output logic       cs_n,
  output logic       si,
  input  wire logic  so,
  output logic       rd_valid,
  output logic [7:0] rd_data
);
  // Link idles with clock still and chip select high
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end

  // Mode 0 frame, MSB first; gap comes first so frames stay spaced
  // Pin edges sit 1 ns after a bench clock edge so no sample races them
  task automatic frame(input logic [39:0] d, input int nb, input bit rd);
    #97 cs_n = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      si = d[39 - i];
      #24 sclk = 1'b1;
      rd_data = {rd_data[6:0], so};
      #24 sclk = 1'b0;
    end
    #24 cs_n = 1'b1;
    si = ~si; // Released line must not keep a stale level
    rd_valid = rd;
    #3 rd_valid = 1'b0;
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// >>> test_flash_write_protect.sv
// Self-checking bench of the write-protection and status block
`timescale 1ns/1ps
`default_nettype none

module test_flash_write_protect;
  logic        ref_clk;
  logic        reset = 1'b1;
  logic        wp_n = 1'b1;
  logic        done = 1'b0;
  logic        hold = 1'b0;
  logic        sclk, cs_n, si, so, so_oe, start, susp, quad, qrd, sec, dpd, rd_valid;
  logic [7:0]  code, rd_data;
  logic [23:0] addr, a;
  logic [15:0] status;
  logic [31:0] e;
  logic [7:0]  rd_q[$];
  logic [31:0] op_q[$];
  logic [7:0]  ops[4] = '{8'h02, 8'h20, 8'h52, 8'hD8};
  logic [4:0]  g;
  logic        inv, k, ce;
  int          failures = 0, checked = 0, cycles = 0, seed = 73, oe_cnt = 0, q_cnt = 0, n = 0;

  flash_write_protect #(.SR_WRITE_CYCLES(5)) i_dut (.REF_CLK(ref_clk), .RESET(reset),
    .SCLK(sclk), .CS_N(cs_n), .SI(si), .WP_N(wp_n), .ARRAY_OP_DONE(done), .SO(so),
    .SO_OE(so_oe), .ARRAY_OP_START(start), .ARRAY_OP_CODE(code), .ARRAY_OP_ADDR(addr),
    .ARRAY_SUSPEND(susp), .QUAD_EN(quad), .QUAD_READ_OK(qrd), .SEC_REGS_RO(sec),
    .DEEP_POWER_DOWN(dpd), .STATUS_WORD(status));
  spi_host_model i_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .rd_valid(rd_valid), .rd_data(rd_data));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic send(input logic [39:0] d, input int n);
    i_host.frame(d, n, 1'b0);
  endtask : send

  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    rd_q.push_back(exp);
    i_host.frame({op, 32'h0}, 16, 1'b1);
  endtask : rd

  // Busy must show (or not) and then drop within the limit
  task automatic settle(input bit busy, input int lim);
    bit seen;
    seen = 0;
    repeat (lim)
    begin
      @(posedge ref_clk);
      if (status[0] === 1'b1)
        seen = 1;
      else if (seen)
        break;
    end
    check(seen, busy);
    check(status[0], 1'b0);
  endtask : settle

  task automatic status_write_cmd(input logic [15:0] v, input bit ok);
    send({8'h06, 32'h0}, 8);
    send({8'h01, v, 16'h0}, 24);
    settle(ok, 40);
  endtask : status_write_cmd

  // Guarded region worked out from the guard code and invert bit
  function automatic bit guarded(input logic [4:0] g, input logic inv, input logic [23:0] a);
    logic [21:0] s;
    bit h;
    if (g[2:0] == 3'h0)
      h = 1;
    else if (g[2:1] == 2'h3)
      h = 0;
    else if (!g[4])
    begin
      s = 22'h200000 >> (6 - g[2:0]);
      h = g[3] ? (a[20:0] >= s) : (a[20:0] < 22'h200000 - s);
    end
    else
    begin
      s = 22'h1000 << ((g[2:0] == 3'h5) ? 3 : g[2:0] - 1);
      h = g[3] ? (a[20:0] < s) : (a[20:0] >= 22'h200000 - s);
    end
    return h ^ inv;
  endfunction : guarded

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Cut a hang short
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      end_of_test();
    end
  end

  // Cycles with the readout driver on and with a quad read granted
  always @(posedge ref_clk)
  begin
    if (so_oe === 1'b1)
      oe_cnt++;
    if (qrd === 1'b1)
      q_cnt++;
  end

  // Scoreboard for status reads
  always @(posedge rd_valid)
    check(rd_data, rd_q.size() ? rd_q.pop_front() : 8'hXX);

  // Datapath stand-in; chip erase carries no address worth comparing
  always @(posedge ref_clk)
    if (start === 1'b1)
    begin
      e = op_q.size() ? op_q.pop_front() : 32'hX;
      check({code, (code inside {8'h60, 8'hC7}) ? 24'h0 : addr}, e);
      if (!hold)
      begin
        repeat (3) @(posedge ref_clk);
        done <= 1'b1;
        @(posedge ref_clk);
        done <= 1'b0;
      end
    end

  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check(status, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      g = (i == 0) ? 5'h00 : (i == 1) ? 5'h07 : 5'($random(seed));
      inv = (i == 1) ? 1'b1 : 1'($random(seed));
      status_write_cmd({1'b0, g, 2'b00, 1'b0, inv, 6'h00}, 1'b1);
      rd(8'h05, {1'b0, g, 2'b00});
      for (int j = 0; j < 3; j++)
      begin
        a = (j == 0) ? ($random(seed) & 24'h1FFFFF) : (j == 1) ? 24'h1FF000 : 24'h000FFF;
        k = guarded(g, inv, a);
        send({8'h06, 32'h0}, 8);
        if (!k)
          op_q.push_back({ops[(i + j) % 4], a});
        send({ops[(i + j) % 4], a, 8'h5A}, (ops[(i + j) % 4] == 8'h02) ? 40 : 32);
        settle(!k, 40);
        rd(8'h05, {1'b0, g, k, 1'b0});
      end
      ce = (g[2:0] == 3'h0 && !inv) || (g[2:0] == 3'h7 && inv);
      send({8'h06, 32'h0}, 8);
      if (ce)
        op_q.push_back({i[0] ? 8'hC7 : 8'h60, 24'h0});
      send({i[0] ? 8'hC7 : 8'h60, 32'h0}, 8);
      settle(ce, 40);
    end
    status_write_cmd(16'h1800, 1'b1);
    send({8'h01, 8'h1C, 24'h0}, 16);
    settle(1'b0, 40);
    send({8'h06, 32'h0}, 9);
    rd(8'h05, 8'h18);
    send({8'h06, 32'h0}, 8);
    rd(8'h05, 8'h1A);
    send({8'h04, 32'h0}, 8);
    rd(8'h05, 8'h18);
    status_write_cmd(16'h9800, 1'b1);
    @(posedge ref_clk) wp_n <= 1'b0;
    status_write_cmd(16'h1800, 1'b0);
    rd(8'h05, 8'h9A);
    @(posedge ref_clk) wp_n <= 1'b1;
    send({8'h6B, 32'h0}, 40);
    check(q_cnt, 0);
    status_write_cmd(16'h183B, 1'b1);
    rd(8'h05, 8'h18);
    rd(8'h35, 8'h02);
    check(quad, 1'b1);
    send({8'h6B, 32'h0}, 40);
    check(q_cnt > 0, 1'b1);
    send({8'hB9, 32'h0}, 8);
    repeat (8) @(posedge ref_clk);
    check(dpd, 1'b1);
    n = oe_cnt;
    send({8'h05, 32'h0}, 16);
    check(oe_cnt - n, 0);
    send({8'h06, 32'h0}, 8);
    send({8'hAB, 32'h0}, 8);
    rd(8'h05, 8'h18);
    hold = 1'b1;
    send({8'h06, 32'h0}, 8);
    op_q.push_back({8'h20, 24'h001000});
    send({8'h20, 24'h001000, 8'h00}, 32);
    send({8'h75, 32'h0}, 8);
    repeat (8) @(posedge ref_clk);
    check({susp, status[15]}, 2'b11);
    send({8'h7A, 32'h0}, 8);
    repeat (8) @(posedge ref_clk);
    check({susp, status[15]}, 2'b00);
    @(posedge ref_clk) done <= 1'b1;
    @(posedge ref_clk) done <= 1'b0;
    hold = 1'b0;
    repeat (2) @(posedge ref_clk);
    check(status[1:0], 2'b00);
    status_write_cmd(16'h1804, 1'b1);
    status_write_cmd(16'h1800, 1'b1);
    rd(8'h35, 8'h04);
    check(sec, 1'b1);
    repeat (10) @(posedge ref_clk);
    check(rd_q.size() + op_q.size(), 0);
    check(oe_cnt > 0, 1'b1);
    end_of_test();
  end
endmodule : test_flash_write_protect
`default_nettype wire
